// File: hw/qpio_pkg.sv
package qpio_pkg;
  localparam int qpio_port_w = 8;
  localparam logic [7:0] qpio_latch_reset = 8'hff;
  localparam logic [7:0] qpio_ones = 8'hff;
  // port select codes on the cpu strobe bus
  typedef enum logic [1:0] {
    qpio_sel_addr_data,
    qpio_sel_analog,
    qpio_sel_high_addr,
    qpio_sel_alt_func
  } qpio_sel_t;
  // alternate-function pin positions on the fourth port
  localparam int qpio_p3_rxd = 0;
  localparam int qpio_p3_txd = 1;
  localparam int qpio_p3_ext_interrupt_zero = 2;
  localparam int qpio_p3_ext_interrupt_one = 3;
  localparam int qpio_p3_t0 = 4;
  localparam int qpio_p3_t1 = 5;
  localparam int qpio_p3_wr = 6;
  localparam int qpio_p3_rd = 7;
  // second-port alternate positions
  localparam int qpio_p1_t2 = 0;
  localparam int qpio_p1_timer2_capture_trigger = 1;
  localparam int qpio_p1_ss = 5;
  // third-port pwm positions
  localparam int qpio_p2_pwm0 = 6;
  localparam int qpio_p2_pwm1 = 7;
  // glitch filter on the serial pins
  localparam int qpio_clk_mhz = 125;
  localparam int qpio_glitch_ns = 50;
  localparam int qpio_glitch_cyc =
    (qpio_glitch_ns * qpio_clk_mhz + 999) / 1000;
  // bit positions of each port within the synchronised pin vector
  localparam int qpio_p1_base = qpio_port_w;
  localparam int qpio_p3_base = 3 * qpio_port_w;
  localparam int qpio_ser_clk_bit = 4 * qpio_port_w;
  localparam int qpio_ser_dat_bit = qpio_ser_clk_bit + 1;
  localparam int qpio_sync_w = qpio_ser_dat_bit + 1;
endpackage

// File: hw/qpio_sync_if.sv
`timescale 1ns/100ps
// pin sampling bundle between top and synchroniser
interface qpio_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// File: hw/qpio_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for pin levels
module qpio_sync #(
  parameter int W = 8
)(
  input wire logic core_clk,
  input wire logic resetn,
  qpio_sync_if.dst s
);
  logic [W-1:0] meta;
  logic [W-1:0] stage;
  // first flop feeds only the second
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta <= '1; // idle pin level, so no false edge after reset
      stage <= '1;
    end
    else
    begin
      meta <= s.raw;
      stage <= meta;
    end
  end
  assign s.synced = stage;
endmodule

// File: hw/qpio_glitch.sv
`timescale 1ns/100ps
// rejects pulses shorter than the filter span
module qpio_glitch
  import qpio_pkg::*;
#(
  parameter int CYC = qpio_glitch_cyc
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic [7:0] cnt;
  // output follows only a level held past the span
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= '0;
      dout <= 1'b1;
    end
    else if (din == dout)
      cnt <= '0;
    else if (cnt >= 8'(CYC))
    begin
      dout <= din;
      cnt <= '0;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule

// File: hw/qpio_top.sv
`timescale 1ns/100ps
//------------------------------------------------------------
// Summary of operation
// - first port open-drain, also low addr/data
// - latch write, read latch, read pin strobes
// - external access sets first latch to ones
// - external control drives first port push-pull
// - first port one floats, zero drives low
// - second port never drives digital output
// - second latch resets one, zero means digital
// - second port pins feed timer2, slave select
// - third port pulled up, emits address bytes
// - third port address drive keeps latch
// - third port one pulled high, zero low
// - pwm routing overrides third port pins 6,7 unless address drive is on
// - fourth port pulled up, zero drives low
// - fourth alternate acts only when latch one
// - fourth port pin alternate function map
// - pwm routing overrides fourth port pins 4,3
// - enabled peripheral takes the pin over
// - i2c weak pull-up, spi push-pull drive
// - i2c inputs reject glitches up to 50ns
// - i2c master bits drive serial pins directly
// - miso uses fourth port pin 3 structure
// - read-modify-write reads the latch
//------------------------------------------------------------
module qpio_top
(
  input wire logic core_clk,
  input wire logic resetn,
  // cpu strobes
  input wire qpio_pkg::qpio_sel_t cpu_sel,
  input wire logic cpu_write_latch,
  input wire logic cpu_read_latch,
  input wire logic cpu_read_pin,
  input wire logic [qpio_pkg::qpio_port_w-1:0] cpu_wdata,
  output logic [qpio_pkg::qpio_port_w-1:0] cpu_rdata,
  // external memory cycle control
  input wire logic ext_mem_ctrl,
  input wire logic ext_mem_p0_use,
  input wire logic ext_mem_p2_use,
  input wire logic [7:0] ext_addr_data,
  input wire logic [7:0] ext_addr_high,
  input wire logic ext_wr_strobe,
  input wire logic ext_rd_strobe,
  // chip config routing
  input wire logic pwm_to_p2,
  input wire logic pwm_to_p3,
  input wire logic pwm0,
  input wire logic pwm1,
  // peripheral outputs and enables
  input wire logic uart_txd,
  input wire logic uart_rxd_out,
  input wire logic uart_rxd_oe,
  input wire logic spi_miso_en,
  input wire logic spi_miso,
  // serial pins
  input wire logic serial_spi_select,
  input wire logic spi_sclk_out,
  input wire logic spi_serial_data_pin_out,
  input wire logic spi_drive_en,
  input wire logic i2c_sclk_low,
  input wire logic i2c_serial_data_pin_low,
  // pins
  input wire logic [7:0] addr_data_pin_in,
  output logic [7:0] addr_data_pin_out,
  output logic [7:0] addr_data_pin_oe_n,
  input wire logic [7:0] analog_pin_in,
  output logic [7:0] analog_select,
  input wire logic [7:0] high_addr_pin_in,
  output logic [7:0] high_addr_pin_out,
  output logic [7:0] high_addr_pin_oe_n,
  input wire logic [7:0] alt_pin_in,
  output logic [7:0] alt_pin_out,
  output logic [7:0] alt_pin_oe_n,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n,
  output logic serial_clock_strong,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe_n,
  output logic serial_data_strong,
  // peripheral inputs
  output logic timer2_ext_input,
  output logic timer2_capture_trigger,
  output logic spi_slave_select_n,
  output logic uart_rxd,
  output logic ext_interrupt_zero,
  output logic ext_interrupt_one,
  output logic timer0_ext_input,
  output logic timer1_ext_input,
  output logic i2c_sclk_in,
  output logic i2c_serial_data_pin_in
);
  import qpio_pkg::*;

  logic [7:0] addr_data_port_latch;
  logic [7:0] analog_input_port_latch;
  logic [7:0] high_addr_port_latch;
  logic [7:0] alt_function_port_latch;
  logic [7:0] alt_drive;
  logic [7:0] next_alt_out;
  logic ser_clk_sync;
  logic ser_dat_sync;

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  qpio_sync_if #(.W(qpio_sync_w)) pin_s ();
  assign pin_s.raw = {serial_data_pin_in, serial_clock_pin_in, alt_pin_in,
    high_addr_pin_in, analog_pin_in, addr_data_pin_in};

  qpio_sync #(.W(qpio_sync_w)) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .s(pin_s)
  );
  assign ser_clk_sync = pin_s.synced[qpio_ser_clk_bit];
  assign ser_dat_sync = pin_s.synced[qpio_ser_dat_bit];

  // port pin slice from the synced vector
  function automatic logic [7:0] pin_of(input qpio_sel_t sel,
    input logic [qpio_sync_w-1:0] v);
    pin_of = v[qpio_port_w*sel +: qpio_port_w];
  endfunction

  //------------------------------------------------------------
  // latches
  //------------------------------------------------------------
  // first port: cpu write, external access forces ones
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      addr_data_port_latch <= qpio_latch_reset;
    else if (ext_mem_p0_use)
      addr_data_port_latch <= qpio_ones;
    else if (cpu_write_latch && cpu_sel == qpio_sel_addr_data)
      addr_data_port_latch <= cpu_wdata;
  end

  // second port: powers up selecting analog
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      analog_input_port_latch <= qpio_latch_reset;
    else if (cpu_write_latch && cpu_sel == qpio_sel_analog)
      analog_input_port_latch <= cpu_wdata;
  end

  // third port: external addressing leaves the latch alone
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      high_addr_port_latch <= qpio_latch_reset;
    else if (cpu_write_latch && cpu_sel == qpio_sel_high_addr)
      high_addr_port_latch <= cpu_wdata;
  end

  // fourth port latch
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      alt_function_port_latch <= qpio_latch_reset;
    else if (cpu_write_latch && cpu_sel == qpio_sel_alt_func)
      alt_function_port_latch <= cpu_wdata;
  end

  //------------------------------------------------------------
  // cpu read path
  //------------------------------------------------------------
  // read-latch feeds read-modify-write so loaded pins never lie
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      cpu_rdata <= '0;
    else if (cpu_read_latch)
      unique case (cpu_sel)
        qpio_sel_addr_data: cpu_rdata <= addr_data_port_latch;
        qpio_sel_analog: cpu_rdata <= analog_input_port_latch;
        qpio_sel_high_addr: cpu_rdata <= high_addr_port_latch;
        qpio_sel_alt_func: cpu_rdata <= alt_function_port_latch;
      endcase
    else if (cpu_read_pin)
      cpu_rdata <= pin_of(cpu_sel, pin_s.synced);
  end

  //------------------------------------------------------------
  // first port drive
  //------------------------------------------------------------
  // open drain in gpio mode, push-pull during external cycles
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_data_pin_out <= '0;
      addr_data_pin_oe_n <= qpio_ones;
    end
    else if (ext_mem_ctrl)
    begin
      addr_data_pin_out <= ext_addr_data;
      addr_data_pin_oe_n <= '0;
    end
    else
    begin
      addr_data_pin_out <= '0;
      addr_data_pin_oe_n <= addr_data_port_latch;
    end
  end

  //------------------------------------------------------------
  // second port: inputs only
  //------------------------------------------------------------
  // analog select comes from the latch; no output driver exists
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      analog_select <= qpio_latch_reset;
      timer2_ext_input <= 1'b1;
      timer2_capture_trigger <= 1'b1;
      spi_slave_select_n <= 1'b1;
    end
    else
    begin
      analog_select <= analog_input_port_latch;
      timer2_ext_input <= pin_s.synced[qpio_p1_base + qpio_p1_t2];
      timer2_capture_trigger <= pin_s.synced[qpio_p1_base + qpio_p1_timer2_capture_trigger];
      spi_slave_select_n <= pin_s.synced[qpio_p1_base + qpio_p1_ss];
    end
  end

  //------------------------------------------------------------
  // third port drive
  //------------------------------------------------------------
  // pull-up holds latch ones high, so only latch zeros enable the driver; address and pwm pins are push-pull
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      high_addr_pin_out <= '0;
      high_addr_pin_oe_n <= qpio_ones;
    end
    else if (ext_mem_p2_use)
    begin
      high_addr_pin_out <= ext_addr_high;
      high_addr_pin_oe_n <= '0;
    end
    else
    begin
      high_addr_pin_out <= high_addr_port_latch;
      high_addr_pin_oe_n <= high_addr_port_latch;
      if (pwm_to_p2)
      begin
        high_addr_pin_out[qpio_p2_pwm0] <= pwm0;
        high_addr_pin_out[qpio_p2_pwm1] <= pwm1;
        high_addr_pin_oe_n[qpio_p2_pwm0] <= 1'b0;
        high_addr_pin_oe_n[qpio_p2_pwm1] <= 1'b0;
      end
    end
  end

  //------------------------------------------------------------
  // fourth port drive
  //------------------------------------------------------------
  // alternate outputs are anded with the latch
  always_comb
  begin
    alt_drive = qpio_ones;
    alt_drive[qpio_p3_rxd] = uart_rxd_oe ? uart_rxd_out : 1'b1;
    alt_drive[qpio_p3_txd] = uart_txd;
    alt_drive[qpio_p3_wr] = ext_wr_strobe;
    alt_drive[qpio_p3_rd] = ext_rd_strobe;
    if (spi_miso_en)
      alt_drive[qpio_p3_ext_interrupt_one] = spi_miso;
    if (pwm_to_p3)
    begin
      alt_drive[qpio_p3_ext_interrupt_one] = pwm1;
      alt_drive[qpio_p3_t0] = pwm0;
    end
    next_alt_out = alt_function_port_latch & alt_drive;
  end

  // low drives strongly; high left to the pull-up
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      alt_pin_out <= '0;
      alt_pin_oe_n <= qpio_ones;
    end
    else
    begin
      alt_pin_out <= next_alt_out;
      alt_pin_oe_n <= next_alt_out;
    end
  end

  // fourth port inputs to peripherals
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      uart_rxd <= 1'b1;
      ext_interrupt_zero <= 1'b1;
      ext_interrupt_one <= 1'b1;
      timer0_ext_input <= 1'b1;
      timer1_ext_input <= 1'b1;
    end
    else
    begin
      uart_rxd <= pin_s.synced[qpio_p3_base + qpio_p3_rxd];
      ext_interrupt_zero <= pin_s.synced[qpio_p3_base + qpio_p3_ext_interrupt_zero];
      ext_interrupt_one <= pin_s.synced[qpio_p3_base + qpio_p3_ext_interrupt_one];
      timer0_ext_input <= pin_s.synced[qpio_p3_base + qpio_p3_t0];
      timer1_ext_input <= pin_s.synced[qpio_p3_base + qpio_p3_t1];
    end
  end

  //------------------------------------------------------------
  // serial clock and data pins
  //------------------------------------------------------------
  // spi drives push-pull; i2c pulls low only, weak pull-up
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe_n <= 1'b1;
      serial_clock_strong <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe_n <= 1'b1;
      serial_data_strong <= 1'b0;
    end
    else if (serial_spi_select)
    begin
      serial_clock_pin_out <= spi_sclk_out;
      serial_clock_pin_oe_n <= !spi_drive_en;
      serial_clock_strong <= 1'b1;
      serial_data_pin_out <= spi_serial_data_pin_out;
      serial_data_pin_oe_n <= !spi_drive_en;
      serial_data_strong <= 1'b1;
    end
    else
    begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe_n <= !i2c_sclk_low;
      serial_clock_strong <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_data_pin_oe_n <= !i2c_serial_data_pin_low;
      serial_data_strong <= 1'b0;
    end
  end

  // i2c input filters; the span is rounded up to whole cycles
  qpio_glitch u_flt_clk (
    .core_clk(core_clk),
    .resetn(resetn),
    .din(ser_clk_sync),
    .dout(i2c_sclk_in)
  );

  qpio_glitch u_flt_dat (
    .core_clk(core_clk),
    .resetn(resetn),
    .din(ser_dat_sync),
    .dout(i2c_serial_data_pin_in)
  );
endmodule

// File: bench/qpio_pins.sv
`timescale 1ns/100ps
// ------
// pad model
// ------
module qpio_pins (
  input wire logic [7:0] addr_data_pin_out,
  input wire logic [7:0] addr_data_pin_oe_n,
  input wire logic [7:0] high_addr_pin_out,
  input wire logic [7:0] high_addr_pin_oe_n,
  input wire logic [7:0] alt_pin_out,
  input wire logic [7:0] alt_pin_oe_n,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe_n,
  input wire logic serial_data_pin_out,
  input wire logic serial_data_pin_oe_n,
  input wire logic [25:0] pull_low,
  output logic [7:0] addr_data_pin_in,
  output logic [7:0] high_addr_pin_in,
  output logic [7:0] alt_pin_in,
  output logic serial_clock_pin_in,
  output logic serial_data_pin_in
);
  // released pads go to the pull-up level, never keep a stale value;
  // first port leans on board resistors, the others on internal ones
  assign addr_data_pin_in = ~pull_low[7:0] &
    (addr_data_pin_out | addr_data_pin_oe_n);
  assign high_addr_pin_in = ~pull_low[15:8] &
    (high_addr_pin_out | high_addr_pin_oe_n);
  assign alt_pin_in = ~pull_low[23:16] &
    (alt_pin_out | alt_pin_oe_n);
  // weak pull-up on the serial pads
  assign serial_clock_pin_in = ~pull_low[24] &
    (serial_clock_pin_out | serial_clock_pin_oe_n);
  assign serial_data_pin_in = ~pull_low[25] &
    (serial_data_pin_out | serial_data_pin_oe_n);
endmodule

// File: bench/qpio_top_properties.sv
`timescale 1ns/100ps
// ------
// port block properties
// ------
module qpio_props (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ext_mem_ctrl,
  input wire logic ext_mem_p2_use,
  input wire logic [7:0] ext_addr_data,
  input wire logic [7:0] ext_addr_high,
  input wire logic [7:0] addr_data_pin_out,
  input wire logic [7:0] addr_data_pin_oe_n,
  input wire logic [7:0] high_addr_pin_out,
  input wire logic [7:0] high_addr_pin_oe_n,
  input wire logic [7:0] alt_pin_out,
  input wire logic [7:0] alt_pin_oe_n,
  input wire logic [7:0] analog_pin_in,
  input wire logic [7:0] analog_select,
  input wire logic pwm_to_p2,
  input wire logic pwm_to_p3,
  input wire logic pwm0,
  input wire logic pwm1,
  input wire logic serial_spi_select,
  input wire logic spi_drive_en,
  input wire logic serial_clock_strong,
  input wire logic serial_data_strong,
  input wire logic timer2_ext_input,
  input wire logic spi_slave_select_n
);
  // pad level as the outside sees it: released bits read high
  wire logic [7:0] lvl2 = high_addr_pin_out | high_addr_pin_oe_n;
  wire logic [7:0] lvl3 = alt_pin_out | alt_pin_oe_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // settled inputs only: outputs are registered one edge late
  p0_addr_drive_a: assert property (
    (ext_mem_ctrl && $stable(ext_addr_data)) [*3] |->
    addr_data_pin_oe_n == 8'h00 && addr_data_pin_out == ext_addr_data)
    else $error("first port not driving address");
  p0_drain_only_a: assert property (
    (!ext_mem_ctrl) [*3] |->
    (addr_data_pin_out & ~addr_data_pin_oe_n) == 8'h00)
    else $error("first port drives high");
  p2_addr_drive_a: assert property (
    (ext_mem_p2_use && !pwm_to_p2 && $stable(ext_addr_high)) [*3] |->
    high_addr_pin_oe_n == 8'h00 && high_addr_pin_out == ext_addr_high)
    else $error("third port not driving address");
  p2_pwm_route_a: assert property (
    (pwm_to_p2 && !ext_mem_p2_use && $stable({pwm0, pwm1})) [*3] |->
    lvl2[7:6] == {pwm1, pwm0})
    else $error("third port pwm not routed");
  p3_pwm_route_a: assert property (
    (pwm_to_p3 && $stable({pwm0, pwm1})) [*3] |->
    lvl3[4] == pwm0 && lvl3[3] == pwm1)
    else $error("fourth port pwm not routed");
  i2c_weak_a: assert property (
    (!serial_spi_select) [*2] |->
    !serial_clock_strong && !serial_data_strong)
    else $error("strong drive in i2c mode");
  spi_strong_a: assert property (
    (serial_spi_select && spi_drive_en) [*2] |->
    serial_clock_strong && serial_data_strong)
    else $error("no strong drive in spi mode");
  analog_reset_a: assert property (
    $rose(resetn) |-> analog_select == 8'hff)
    else $error("second latch not ones after reset");
  t2_input_path_a: assert property (
    ($stable(analog_pin_in) && analog_select[0] == 1'b0 &&
    analog_select[5] == 1'b0) [*5] |-> timer2_ext_input ==
    analog_pin_in[0] && spi_slave_select_n == analog_pin_in[5])
    else $error("second port input path wrong");
  // main scenarios reached
  cover property (ext_mem_ctrl ##1 !ext_mem_ctrl);
  cover property (pwm_to_p2 && pwm_to_p3);
  cover property (serial_spi_select ##1 !serial_spi_select);
endmodule
bind qpio_top qpio_props qpio_props_i (.*);

// File: bench/testbench.sv
`timescale 1ns/100ps
// ------
// port block regression
// ------
module testbench;
  import qpio_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, acc = 1'b1;
  qpio_sel_t cpu_sel = qpio_sel_addr_data;
  logic cpu_write_latch = 1'b0, cpu_read_latch = 1'b0, cpu_read_pin = 1'b0;
  logic [7:0] cpu_wdata = 8'h00, ext_addr_data = 8'h00;
  logic [7:0] ext_addr_high = 8'h00, analog_pin_in = 8'hff;
  logic ext_mem_ctrl = 1'b0, ext_mem_p0_use = 1'b0, ext_mem_p2_use = 1'b0;
  logic ext_wr_strobe = 1'b1, ext_rd_strobe = 1'b1, uart_txd = 1'b1;
  logic pwm_to_p2 = 1'b0, pwm_to_p3 = 1'b0, pwm0 = 1'b0, pwm1 = 1'b0;
  logic serial_spi_select = 1'b0, spi_drive_en = 1'b0;
  logic spi_sclk_out = 1'b0, spi_serial_data_pin_out = 1'b0;
  logic i2c_sclk_low = 1'b0, i2c_serial_data_pin_low = 1'b0;
  // receive and miso drive start idle; the pwm test turns them on
  logic uart_rxd_out = 1'b0, uart_rxd_oe = 1'b0;
  logic spi_miso_en = 1'b0, spi_miso = 1'b0;
  logic [25:0] pull_low = '0;
  logic [7:0] cpu_rdata, analog_select, addr_data_pin_out, addr_data_pin_oe_n;
  logic [7:0] high_addr_pin_out, high_addr_pin_oe_n, alt_pin_out;
  logic [7:0] alt_pin_oe_n, addr_data_pin_in, high_addr_pin_in, alt_pin_in;
  logic serial_clock_pin_in, serial_clock_pin_out, serial_clock_pin_oe_n;
  logic serial_data_pin_in, serial_data_pin_out, serial_data_pin_oe_n;
  logic serial_clock_strong, serial_data_strong, timer2_ext_input;
  logic timer2_capture_trigger, spi_slave_select_n, uart_rxd;
  logic ext_interrupt_zero, ext_interrupt_one, timer0_ext_input;
  logic timer1_ext_input, i2c_sclk_in, i2c_serial_data_pin_in;
  int n_fail = 0, num_checks = 0;
  qpio_top qpio_top_i (.*);
  qpio_pins qpio_pins_i (.*);
  // 125 MHz core clock
  always #4 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // look mid-cycle so registered outputs have landed
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic wr(input qpio_sel_t s, input logic [7:0] d);
    @(posedge core_clk);
    cpu_sel <= s;
    cpu_wdata <= d;
    cpu_write_latch <= 1'b1;
    @(posedge core_clk);
    cpu_write_latch <= 1'b0;
  endtask
  task automatic rd(input qpio_sel_t s, input logic lat, input logic [7:0] e);
    @(posedge core_clk);
    cpu_sel <= s;
    cpu_read_latch <= lat;
    cpu_read_pin <= ~lat;
    @(posedge core_clk);
    cpu_read_latch <= 1'b0;
    cpu_read_pin <= 1'b0;
    @(negedge core_clk);
    chk(cpu_rdata, e);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    for (int p = 0; p < 4; p++)
      rd(qpio_sel_t'(p), 1'b1, qpio_latch_reset);
    chk(analog_select, 8'hff);
    done("reset");
    // pad held low outside: latch and pin must differ
    wr(qpio_sel_high_addr, 8'h81);
    @(posedge core_clk);
    pull_low <= 26'h100;
    w(4);
    rd(qpio_sel_high_addr, 1'b0, 8'h80);
    rd(qpio_sel_high_addr, 1'b1, 8'h81);
    pull_low <= '0;
    wr(qpio_sel_addr_data, 8'h5a);
    w(2);
    chk(addr_data_pin_oe_n, 8'h5a);
    chk(addr_data_pin_in, 8'h5a);
    done("latch");
    @(posedge core_clk);
    ext_mem_ctrl <= 1'b1;
    ext_mem_p0_use <= 1'b1;
    ext_mem_p2_use <= 1'b1;
    ext_addr_data <= 8'h3c;
    ext_addr_high <= 8'hc3;
    w(3);
    chk(addr_data_pin_in, 8'h3c);
    chk(high_addr_pin_in, 8'hc3);
    @(posedge core_clk);
    ext_mem_ctrl <= 1'b0;
    ext_mem_p0_use <= 1'b0;
    ext_mem_p2_use <= 1'b0;
    rd(qpio_sel_addr_data, 1'b1, qpio_ones);
    rd(qpio_sel_high_addr, 1'b1, 8'h81);
    done("external");
    wr(qpio_sel_high_addr, 8'h00);
    pwm_to_p2 <= 1'b1;
    pwm_to_p3 <= 1'b1;
    pwm0 <= 1'b1;
    w(3);
    chk({6'h00, high_addr_pin_in[7:6]}, 8'h01);
    chk({6'h00, alt_pin_in[4:3]}, 8'h02);
    // miso and receive drive take pins 3 and 0 once pwm lets go
    @(posedge core_clk);
    pwm_to_p2 <= 1'b0;
    pwm_to_p3 <= 1'b0;
    spi_miso_en <= 1'b1;
    uart_rxd_oe <= 1'b1;
    w(4);
    chk(alt_pin_in, 8'hf6);
    chk({4'h0, uart_rxd, ext_interrupt_one, timer0_ext_input,
      timer1_ext_input}, 8'h03);
    @(posedge core_clk);
    spi_miso_en <= 1'b0;
    uart_rxd_oe <= 1'b0;
    done("pwm");
    // latch zero holds the pin low, read strobe shows on pin 7
    wr(qpio_sel_alt_func, 8'hfd);
    ext_rd_strobe <= 1'b0;
    pull_low <= 26'h40000;
    w(4);
    chk(alt_pin_in, 8'h79);
    chk({7'h00, ext_interrupt_zero}, 8'h00);
    rd(qpio_sel_alt_func, 1'b0, 8'h79);
    pull_low <= '0;
    wr(qpio_sel_analog, 8'h00);
    analog_pin_in <= 8'h21;
    w(5);
    chk(analog_select, 8'h00);
    chk({spi_slave_select_n, timer2_capture_trigger, timer2_ext_input},
      8'h05);
    done("alternate");
    @(posedge core_clk);
    i2c_sclk_low <= 1'b1;
    w(3);
    chk({serial_clock_strong, serial_clock_pin_in}, 8'h00);
    // a pulse just under the filter span must not get through
    pull_low <= 26'h2000000;
    repeat (qpio_glitch_cyc - 1) @(posedge core_clk);
    pull_low <= '0;
    repeat (20)
    begin
      @(negedge core_clk);
      acc &= i2c_serial_data_pin_in;
    end
    chk({7'h00, acc}, 8'h01);
    @(posedge core_clk);
    pull_low <= 26'h2000000;
    w(20);
    chk({6'h00, i2c_sclk_in, i2c_serial_data_pin_in}, 8'h00);
    @(posedge core_clk);
    pull_low <= '0;
    i2c_sclk_low <= 1'b0;
    serial_spi_select <= 1'b1;
    spi_drive_en <= 1'b1;
    spi_serial_data_pin_out <= 1'b1;
    w(3);
    chk({serial_clock_strong, serial_clock_pin_in, serial_data_pin_in},
      8'h05);
    // back to i2c: strong drive off, software pulls data low
    @(posedge core_clk);
    serial_spi_select <= 1'b0;
    spi_drive_en <= 1'b0;
    i2c_serial_data_pin_low <= 1'b1;
    w(2);
    chk({serial_clock_strong, serial_data_strong, serial_data_pin_in},
      8'h00);
    done("serial");
    give_verdict();
  end
endmodule
